//--- logic/pdmac_channels.sv
// thirteen-channel peripheral dma engine with fixed priority and buffer chaining
`timescale 1ns/100ps
`include "pdmac_regs.svh"

module pdmac_channels
#(
   parameter int NUM_CHAN = `PDMAC_NUM_CHAN,
   parameter int NUM_RX = `PDMAC_NUM_RX,
   parameter int XFER_BYTES = `PDMAC_XFER_BYTES
)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic ce,
   input wire pdmac_pkg::pdmac_cfg_t cfg,
   input wire logic [NUM_CHAN-1:0] chanReq,
   input wire logic busGrant,
   input wire logic [`PDMAC_DATA_W-1:0] memRdata,
   input wire logic [`PDMAC_DATA_W-1:0] perRdata,
   output logic busReq,
   output pdmac_pkg::pdmac_mem_t memBus,
   output pdmac_pkg::pdmac_per_t perBus,
   output logic [NUM_CHAN-1:0] endBuf
);
   // channel index order is priority order: 0..6 receive, 7..12 transmit
   // receive: debug unit, usart0, usart1, sync serial, converter, spi0, spi1
   // transmit: debug unit, usart0, usart1, sync serial, spi0, spi1
   // the channel map is hard-wired, so other sizes are refused at elaboration
   if (NUM_CHAN != `PDMAC_NUM_CHAN || NUM_RX != `PDMAC_NUM_RX)
   begin : gBadMap
      $error("pdmac_channels: channel map is fixed at 13 channels, 7 receive");
   end
   if (XFER_BYTES != 1 && XFER_BYTES != 2 && XFER_BYTES != 4)
   begin : gBadStep
      $error("pdmac_channels: transfer size must be 1, 2 or 4 bytes");
   end

   localparam logic [`PDMAC_PTR_W-1:0] STEP = `PDMAC_PTR_W'(XFER_BYTES);

   pdmac_pkg::pdmac_state_t state;
   logic [`PDMAC_CHAN_W-1:0] active;
   logic [`PDMAC_PTR_W-1:0] curPtr [NUM_CHAN];
   logic [`PDMAC_CNT_W-1:0] curCnt [NUM_CHAN];
   logic [`PDMAC_PTR_W-1:0] nextPtr [NUM_CHAN];
   logic [`PDMAC_CNT_W-1:0] nextCnt [NUM_CHAN];
   logic [NUM_CHAN-1:0] eligible;
   logic [NUM_CHAN-1:0] stepChan;
   logic [`PDMAC_CHAN_W-1:0] next_pick;
   logic pickValid;

   // a channel with an empty current buffer cannot ask; chaining refills it first
   always_comb
   begin
      for (int i = 0; i < NUM_CHAN; i++)
      begin
         eligible[i] = chanReq[i] && (curCnt[i] != `PDMAC_CNT_RESET);
      end
   end

   // lowest index wins, so receive always beats transmit
   always_comb
   begin
      next_pick = '0;
      pickValid = 1'b0;
      for (int i = NUM_CHAN - 1; i >= 0; i--)
      begin
         if (eligible[i])
         begin
            next_pick = `PDMAC_CHAN_W'(i);
            pickValid = 1'b1;
         end
      end
   end

   // pointer/count step fires in the last bus cycle of a transfer
   always_comb
   begin
      stepChan = '0;
      if (state == pdmac_pkg::PDMAC_RX2 || state == pdmac_pkg::PDMAC_TX1)
      begin
         stepChan[active] = 1'b1;
      end
   end

   // sequencer
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         state <= pdmac_pkg::PDMAC_IDLE;
         active <= '0;
      end
      else if (ce)
      begin
         unique case (state)
            pdmac_pkg::PDMAC_IDLE:
            begin
               if (pickValid)
               begin
                  active <= next_pick;
                  state <= pdmac_pkg::PDMAC_REQ;
               end
            end
            pdmac_pkg::PDMAC_REQ:
            begin
               // wait for the arbiter, which also serves the core and the mac
               if (busGrant)
               begin
                  state <= (active < `PDMAC_CHAN_W'(NUM_RX)) ? pdmac_pkg::PDMAC_RX1
                                                              : pdmac_pkg::PDMAC_TX1;
               end
            end
            pdmac_pkg::PDMAC_RX1: state <= pdmac_pkg::PDMAC_RX2;
            pdmac_pkg::PDMAC_RX2: state <= pdmac_pkg::PDMAC_IDLE;
            pdmac_pkg::PDMAC_TX1: state <= pdmac_pkg::PDMAC_TX2;
            pdmac_pkg::PDMAC_TX2: state <= pdmac_pkg::PDMAC_IDLE;
            default: state <= pdmac_pkg::PDMAC_IDLE;
         endcase
      end
   end

   // bus request held from selection until the last bus cycle
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         busReq <= 1'b0;
      end
      else if (ce)
      begin
         if (state == pdmac_pkg::PDMAC_IDLE && pickValid)
         begin
            busReq <= 1'b1;
         end
         else if (state == pdmac_pkg::PDMAC_RX2 || state == pdmac_pkg::PDMAC_TX1)
         begin
            busReq <= 1'b0;
         end
      end
   end

   // memory side: tx reads in one granted cycle, rx writes in the second
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         memBus <= '0;
      end
      else if (ce)
      begin
         memBus.read <= 1'b0;
         memBus.write <= 1'b0;
         if (state == pdmac_pkg::PDMAC_REQ && busGrant && active >= `PDMAC_CHAN_W'(NUM_RX))
         begin
            memBus.read <= 1'b1;
            memBus.addr <= curPtr[active];
         end
         else if (state == pdmac_pkg::PDMAC_RX1)
         begin
            memBus.write <= 1'b1;
            memBus.addr <= curPtr[active];
            memBus.wdata <= perRdata;
         end
      end
   end

   // peripheral side: rx read strobe in first granted cycle, tx write after the bus read
   // read data lands the cycle after the bus cycle, so the bus is already free
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         perBus <= '0;
      end
      else if (ce)
      begin
         perBus.read <= 1'b0;
         perBus.write <= 1'b0;
         if (state == pdmac_pkg::PDMAC_REQ && busGrant && active < `PDMAC_CHAN_W'(NUM_RX))
         begin
            perBus.read <= 1'b1;
            perBus.chan <= active;
         end
         else if (state == pdmac_pkg::PDMAC_TX2)
         begin
            perBus.write <= 1'b1;
            perBus.chan <= active;
            perBus.wdata <= memRdata;
         end
      end
   end

   // per-channel buffer state; a configuration write wins over a same-cycle step
   for (genvar c = 0; c < NUM_CHAN; c++)
   begin : gChan
      logic cfgHit;
      assign cfgHit = cfg.write && (cfg.chan == `PDMAC_CHAN_W'(c));

      always_ff @(posedge clock)
      begin
         if (!rst_b)
         begin
            curPtr[c] <= `PDMAC_PTR_RESET;
            curCnt[c] <= `PDMAC_CNT_RESET;
            nextPtr[c] <= `PDMAC_PTR_RESET;
            nextCnt[c] <= `PDMAC_CNT_RESET;
         end
         else if (ce)
         begin
            if (stepChan[c])
            begin
               if (curCnt[c] == `PDMAC_CNT_W'(1) && nextCnt[c] != `PDMAC_CNT_RESET)
               begin
                  // chain into the next buffer with no software turn-around
                  curPtr[c] <= nextPtr[c];
                  curCnt[c] <= nextCnt[c];
                  nextCnt[c] <= `PDMAC_CNT_RESET;
               end
               else
               begin
                  curPtr[c] <= curPtr[c] + STEP;
                  curCnt[c] <= curCnt[c] - `PDMAC_CNT_W'(1);
               end
            end
            if (cfgHit && cfg.sel == `PDMAC_SEL_CUR)
            begin
               curPtr[c] <= cfg.ptr;
               curCnt[c] <= cfg.cnt;
            end
            if (cfgHit && cfg.sel == `PDMAC_SEL_NEXT)
            begin
               nextPtr[c] <= cfg.ptr;
               nextCnt[c] <= cfg.cnt;
            end
         end
      end

      // end of buffer: set when the last word leaves with no next buffer, set beats clear
      always_ff @(posedge clock)
      begin
         if (!rst_b)
         begin
            endBuf[c] <= 1'b0;
         end
         else if (ce)
         begin
            if (stepChan[c] && curCnt[c] == `PDMAC_CNT_W'(1) && nextCnt[c] == `PDMAC_CNT_RESET)
            begin
               endBuf[c] <= 1'b1;
            end
            else if (cfgHit && cfg.cnt != `PDMAC_CNT_RESET)
            begin
               endBuf[c] <= 1'b0;
            end
         end
      end
   end
endmodule

//--- logic/pdmac_pkg.sv
// types shared by the peripheral dma engine
package pdmac_pkg;
   typedef enum logic [2:0]
   {
      PDMAC_IDLE = 3'h0,
      PDMAC_REQ = 3'h1,
      PDMAC_RX1 = 3'h3,
      PDMAC_RX2 = 3'h2,
      PDMAC_TX1 = 3'h5,
      PDMAC_TX2 = 3'h4
   } pdmac_state_t;

   typedef struct packed
   {
      logic write;
      logic [3:0] chan;
      logic sel;
      logic [31:0] ptr;
      logic [15:0] cnt;
   } pdmac_cfg_t;

   typedef struct packed
   {
      logic read;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } pdmac_mem_t;

   typedef struct packed
   {
      logic read;
      logic write;
      logic [3:0] chan;
      logic [31:0] wdata;
   } pdmac_per_t;
endpackage

//--- logic/pdmac_regs.svh
// constants for the peripheral dma engine
`ifndef PDMAC_REGS_SVH
`define PDMAC_REGS_SVH
`define PDMAC_NUM_CHAN 13
`define PDMAC_NUM_RX 7
`define PDMAC_PTR_W 32
`define PDMAC_CNT_W 16
`define PDMAC_DATA_W 32
`define PDMAC_CHAN_W 4
`define PDMAC_XFER_BYTES 4
`define PDMAC_PTR_RESET 32'h00000000
`define PDMAC_CNT_RESET 16'h0000
`define PDMAC_SEL_CUR 1'b0
`define PDMAC_SEL_NEXT 1'b1
`define PDMAC_RX_BUS_CYCLES 2
`define PDMAC_TX_BUS_CYCLES 1
`endif

//--- verif/pdmac_channels_props.sv
// assertions on the peripheral dma engine ports
`timescale 1ns/100ps
module pdmac_channels_props
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic busGrant,
   input wire logic [31:0] memRdata,
   input wire logic [31:0] perRdata,
   input wire logic busReq,
   input wire pdmac_pkg::pdmac_mem_t memBus,
   input wire pdmac_pkg::pdmac_per_t perBus
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_tx_one_cycle: assert property (memBus.read |=>
      !memBus.read && !memBus.write && !busReq)
      else $error("tx bus hold wrong");
   a_rx_two_cycle: assert property (perBus.read |=>
      (memBus.write && busReq) ##1 !busReq)
      else $error("rx bus hold wrong");
   a_rx_data_path: assert property (perBus.read |=> memBus.wdata == $past(perRdata))
      else $error("rx data lost");
   a_tx_data_path: assert property (memBus.read |-> ##2
      perBus.write && perBus.wdata == $past(memRdata))
      else $error("tx data lost");
   a_bus_granted: assert property ((memBus.read || perBus.read) |->
      busReq && $past(busGrant))
      else $error("bus used without grant");
   a_bus_owner: assert property ((memBus.read || memBus.write) |-> busReq)
      else $error("memory strobe without request");
   a_rx_chan_range: assert property (perBus.read |-> perBus.chan < 4'h7)
      else $error("rx on tx channel");
   a_tx_chan_range: assert property (perBus.write |-> perBus.chan inside {[4'h7:4'hc]})
      else $error("tx on bad channel");
endmodule
bind pdmac_channels pdmac_channels_props u_pdmac_channels_props (.clock(clock), .rst_b(rst_b),
   .busGrant(busGrant), .memRdata(memRdata), .perRdata(perRdata), .busReq(busReq),
   .memBus(memBus), .perBus(perBus));

//--- verif/pdmac_channels_test.sv
// self-checking bench for the peripheral dma engine
`timescale 1ns/100ps
module pdmac_channels_test;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   pdmac_pkg::pdmac_cfg_t cfg = '0;
   logic [12:0] chanReq = 13'h0;
   logic [3:0] grantDly = 4'h0;
   logic busGrant, busReq;
   logic [31:0] memRdata, perRdata, lastAddr;
   logic [3:0] lastChan;
   pdmac_pkg::pdmac_mem_t memBus;
   pdmac_pkg::pdmac_per_t perBus;
   logic [12:0] endBuf;
   int failures = 0;
   int n_tests = 0;
   logic [31:0] expA[$];
   logic [3:0] expC[$];
   always #20 clock = ~clock;
   pdmac_channels u_pdmac_channels (.clock(clock), .rst_b(rst_b), .ce(ce), .cfg(cfg),
      .chanReq(chanReq), .busGrant(busGrant), .memRdata(memRdata), .perRdata(perRdata),
      .busReq(busReq), .memBus(memBus), .perBus(perBus), .endBuf(endBuf));
   pdmac_far_end u_pdmac_far_end (.clock(clock), .rst_b(rst_b), .grantDly(grantDly),
      .busReq(busReq), .memBus(memBus), .perBus(perBus), .busGrant(busGrant),
      .memRdata(memRdata), .perRdata(perRdata));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic cfgw(input logic [3:0] k, input logic s, input logic [31:0] p,
      input logic [15:0] n);
      @(posedge clock);
      #1 cfg = '{1'b1, k, s, p, n};
      @(posedge clock);
      #1 cfg.write = 1'b0;
   endtask
   task automatic wait_end(input int k);
      int i;
      for (i = 0; i < 400 && endBuf[k] !== 1'b1; i++)
         @(posedge clock);
      if (endBuf[k] !== 1'b1)
      begin
         chk("end wait", 32'h1, {31'h0, endBuf[k]});
         give_verdict();
      end
      else
      begin
         repeat (6) @(posedge clock);
         #1;
      end
   endtask
   // every served word is judged mid-cycle, where the strobes have settled
   always @(negedge clock)
   begin
      if (perBus.read || perBus.write)
         chk("chan", expC.pop_front(), {28'h0, perBus.chan});
      if (memBus.read || memBus.write)
         chk("addr", expA.pop_front(), memBus.addr);
      if (memBus.write)
         chk("rx data", {28'hd00d000, lastChan}, memBus.wdata);
      if (perBus.write)
         chk("tx data", lastAddr ^ 32'ha5a5c3c3, perBus.wdata);
      if (perBus.read)
         lastChan <= perBus.chan;
      if (memBus.read)
         lastAddr <= memBus.addr;
   end
   // all thirteen ask at once, one word each
   task automatic test_priority;
      int k;
      for (k = 0; k < 13; k++)
      begin
         cfgw(k[3:0], 1'b0, 32'h1000 + k * 32'h100, 16'h1);
         expC.push_back(k[3:0]);
         expA.push_back(32'h1000 + k * 32'h100);
      end
      chanReq = 13'h1fff;
      wait_end(12);
      chanReq = 13'h0;
      chk("ends", 32'h1fff, {19'h0, endBuf});
      chk("left", 32'h0, expA.size() + expC.size());
      $display("priority test done");
   endtask
   // clock enable low: config write and request are both ignored
   task automatic test_freeze;
      int i;
      ce = 1'b0;
      cfgw(4'h0, 1'b0, 32'h5000, 16'h1);
      chanReq = 13'h001;
      for (i = 0; i < 4; i++)
      begin
         @(posedge clock);
         #1 chk("frozen req", 32'h0, {31'h0, busReq});
      end
      ce = 1'b1;
      repeat (4) @(posedge clock);
      #1 chk("stale req", 32'h0, {31'h0, busReq});
      chk("kept end", 32'h1, {31'h0, endBuf[0]});
      chanReq = 13'h0;
      $display("freeze test done");
   endtask
   // chained buffer under a slow grant, a tx waiting behind
   task automatic test_chain;
      grantDly = 4'h5;
      cfgw(4'h3, 1'b0, 32'h2000, 16'h2);
      chk("cleared", 32'h0, {31'h0, endBuf[3]});
      cfgw(4'h3, 1'b1, 32'h3000, 16'h1);
      cfgw(4'h9, 1'b0, 32'h4000, 16'h1);
      expA = '{32'h2000, 32'h2004, 32'h3000, 32'h4000};
      expC = '{4'h3, 4'h3, 4'h3, 4'h9};
      chanReq = 13'h208;
      wait_end(9);
      chanReq = 13'h0;
      chk("left", 32'h0, expA.size() + expC.size());
      chk("ends", 32'h208, {19'h0, endBuf & 13'h208});
      $display("chain test done");
   endtask
   initial
   begin
      repeat (5) @(posedge clock);
      #1 rst_b = 1'b1;
      chk("reset ends", 32'h0, {19'h0, endBuf});
      chk("reset req", 32'h0, {31'h0, busReq});
      test_priority();
      test_freeze();
      test_chain();
      give_verdict();
   end
endmodule

//--- verif/pdmac_far_end.sv
// arbiter, memory and peripheral data model
`timescale 1ns/100ps
module pdmac_far_end
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [3:0] grantDly,
   input wire logic busReq,
   input wire pdmac_pkg::pdmac_mem_t memBus,
   input wire pdmac_pkg::pdmac_per_t perBus,
   output logic busGrant,
   output logic [31:0] memRdata,
   output logic [31:0] perRdata
);
   logic [3:0] waitCnt;
   // grant after a chosen delay, kept while requested
   always_ff @(posedge clock)
   begin
      if (!rst_b || !busReq)
      begin
         waitCnt <= 4'h0;
         busGrant <= 1'b0;
      end
      else
      begin
         if (waitCnt < grantDly)
            waitCnt <= waitCnt + 4'h1;
         busGrant <= (waitCnt >= grantDly);
      end
   end
   // idle data toggles, so a late sample never matches
   always_ff @(posedge clock)
   begin
      if (!rst_b)
         memRdata <= 32'h0;
      else if (memBus.read)
         memRdata <= memBus.addr ^ 32'ha5a5c3c3;
      else
         memRdata <= ~memRdata;
   end
   assign perRdata = perBus.read ? {28'hd00d000, perBus.chan} : ~{28'hd00d000, perBus.chan};
endmodule
